//--- hw/bank_cfg_pkg.sv
// Function
// (R1) Source select 0, reset value: pins set ratio, bank power-down, style, swing; here the logic holds bank power-down at 0 instead.
// (R2) Source select 1: registers set those settings; control pins ignored.
// (R3) Each output has a power-down bit, reset 0; 1 turns output off.
// (R4) Each output has a style bit, reset 0; 0 LVDS, 1 LVPECL.
// (R5) Each output has two-bit swing, reset 00: 350, 500, 750 mV, 11 reserved.
// (R6) Host writes zero to reserved bits and ignores their read value.
// (R7) New divide ratio applies only after the init bit toggles.
// (R8) Fields stay writable and readable for any source select value.
package bank_cfg_pkg;
  // ==========================================
  // Register indices, byte address is four times index
  localparam logic [7:0] IDX_INIT = 8'h14;
  localparam logic [7:0] IDX_DIV = 8'h15;
  localparam logic [7:0] IDX_BANK = 8'h16;
  localparam logic [7:0] IDX_OUT0 = 8'h18;
  localparam logic [7:0] IDX_OUT1 = 8'h19;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;

  // ==========================================
  // Field positions
  localparam int DIV_W = 6;
  localparam int SWING_W = 2;
  localparam int OUTS = 2;
  localparam int PIN_W = 2;
  localparam int POS_INIT = 0;
  localparam int POS_SRC = 0;
  localparam int POS_BANKPD = 7;
  localparam int POS_OUTPD = 7;
  localparam int POS_STYLE = 2;

  // ==========================================
  // Reset values and codes
  localparam logic [DIV_W-1:0] DIV_RESET = 6'h0d;
  localparam logic [SWING_W-1:0] SWING_350MV = 2'h0;
  localparam logic [SWING_W-1:0] SWING_500MV = 2'h1;
  localparam logic [SWING_W-1:0] SWING_750MV = 2'h2;
  localparam logic STYLE_LVDS = 1'h0;
  localparam logic STYLE_LVPECL = 1'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================
  // Pin presets: ratio, style, swing per pin code
  localparam logic [4*DIV_W-1:0] PIN_DIV = {6'h04, 6'h07, 6'h09, 6'h0d};
  localparam logic [3:0] PIN_STYLE = 4'h6;
  localparam logic [4*SWING_W-1:0] PIN_SWING = {2'h2, 2'h1, 2'h1, 2'h0};
endpackage

//--- hw/pin_sync3.sv
`timescale 1ns/100ps
module pin_sync3 #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // ==========================================
  // Three flops, accept when two and three agree
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinOut <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          pinOut[i] <= stage3[i];
        end
      end
    end
  end
endmodule

//--- hw/output_bank_config_control.sv
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
module output_bank_config_control (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] ctrlPins,
  output logic [5:0] divRatio,
  output logic bankPowerDown,
  output logic [1:0] outPowerDown,
  output logic [1:0] outStyle,
  output logic [3:0] outSwing
);
  localparam int DW = bank_cfg_pkg::DIV_W;
  localparam int SW = bank_cfg_pkg::SWING_W;

  logic rstMeta;
  logic rstSync;
  logic [1:0] pinCode;
  logic awHeld;
  logic wHeld;
  logic [7:0] awIdx;
  logic [31:0] wData;
  logic wLane0;
  logic initBit;
  logic [DW-1:0] divReg;
  logic [DW-1:0] divApplied;
  logic bankPdReg;
  logic bankSourceSelect;
  logic [1:0] outPdReg;
  logic [1:0] styleReg;
  logic [3:0] swingReg;
  logic doWrite;
  logic [7:0] arIdx;
  logic [31:0] next_rdata;
  logic next_rerr;

  // ==========================================
  // Reset release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  pin_sync3 #(.WIDTH(bank_cfg_pkg::PIN_W)) u_pins (
    .clk(sys_clk),
    .rstN(rstSync),
    .pinIn(ctrlPins),
    .pinOut(pinCode)
  );

  // ==========================================
  // Write address and data capture
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      awHeld <= 1'b0;
      awIdx <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awIdx <= s_axi_awaddr[bank_cfg_pkg::IDX_LSB +: 8];
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      wHeld <= 1'b0;
      wData <= '0;
      wLane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wLane0 <= s_axi_wstrb[0];
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wHeld && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= bank_cfg_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      if (awIdx == bank_cfg_pkg::IDX_INIT || awIdx == bank_cfg_pkg::IDX_DIV ||
          awIdx == bank_cfg_pkg::IDX_BANK || awIdx == bank_cfg_pkg::IDX_OUT0 ||
          awIdx == bank_cfg_pkg::IDX_OUT1) begin
        s_axi_bresp <= bank_cfg_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= bank_cfg_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================
  // Register fields
  // (R8) Writes regardless source
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      initBit <= 1'b0;
      divReg <= bank_cfg_pkg::DIV_RESET;
      bankPdReg <= 1'b0;
      bankSourceSelect <= 1'b0;
      outPdReg <= '0;
      styleReg <= '0;
      swingReg <= '0;
    end else if (doWrite && wLane0) begin
      if (awIdx == bank_cfg_pkg::IDX_INIT) begin
        initBit <= wData[bank_cfg_pkg::POS_INIT];
      end else if (awIdx == bank_cfg_pkg::IDX_DIV) begin
        divReg <= wData[DW-1:0];
      end else if (awIdx == bank_cfg_pkg::IDX_BANK) begin
        bankPdReg <= wData[bank_cfg_pkg::POS_BANKPD];
        bankSourceSelect <= wData[bank_cfg_pkg::POS_SRC];
      end else if (awIdx == bank_cfg_pkg::IDX_OUT0) begin
        // (R3) Output power-down
        outPdReg[0] <= wData[bank_cfg_pkg::POS_OUTPD];
        // (R4) Output style
        styleReg[0] <= wData[bank_cfg_pkg::POS_STYLE];
        // (R5) Output swing
        swingReg[SW-1:0] <= wData[SW-1:0];
      end else if (awIdx == bank_cfg_pkg::IDX_OUT1) begin
        outPdReg[1] <= wData[bank_cfg_pkg::POS_OUTPD];
        styleReg[1] <= wData[bank_cfg_pkg::POS_STYLE];
        swingReg[2*SW-1:SW] <= wData[SW-1:0];
      end
    end
  end

  // (R7) Ratio applied on init toggle
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      divApplied <= bank_cfg_pkg::DIV_RESET;
    end else if (doWrite && wLane0 && awIdx == bank_cfg_pkg::IDX_INIT &&
                 wData[bank_cfg_pkg::POS_INIT] != initBit) begin
      divApplied <= divReg;
    end
  end

  // ==========================================
  // Active settings
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      divRatio <= bank_cfg_pkg::DIV_RESET;
      bankPowerDown <= 1'b0;
      outPowerDown <= '0;
      outStyle <= '0;
      outSwing <= '0;
    end else begin
      outPowerDown <= outPdReg;
      if (bankSourceSelect) begin
        // (R2) Registers drive bank
        divRatio <= divApplied;
        bankPowerDown <= bankPdReg;
        outStyle <= styleReg;
        outSwing <= swingReg;
      end else begin
        // (R1) Pins drive bank
        divRatio <= bank_cfg_pkg::PIN_DIV[pinCode*DW +: DW];
        bankPowerDown <= 1'b0;
        outStyle <= {2{bank_cfg_pkg::PIN_STYLE[pinCode]}};
        outSwing <= {2{bank_cfg_pkg::PIN_SWING[pinCode*SW +: SW]}};
      end
    end
  end

  // ==========================================
  // Read decode, reserved bits read zero
  assign arIdx = s_axi_araddr[bank_cfg_pkg::IDX_LSB +: 8];

  always_comb begin
    next_rdata = '0;
    next_rerr = 1'b0;
    if (arIdx == bank_cfg_pkg::IDX_INIT) begin
      next_rdata[bank_cfg_pkg::POS_INIT] = initBit;
    end else if (arIdx == bank_cfg_pkg::IDX_DIV) begin
      next_rdata[DW-1:0] = divReg;
    end else if (arIdx == bank_cfg_pkg::IDX_BANK) begin
      next_rdata[bank_cfg_pkg::POS_BANKPD] = bankPdReg;
      next_rdata[bank_cfg_pkg::POS_SRC] = bankSourceSelect;
    end else if (arIdx == bank_cfg_pkg::IDX_OUT0) begin
      next_rdata[bank_cfg_pkg::POS_OUTPD] = outPdReg[0];
      next_rdata[bank_cfg_pkg::POS_STYLE] = styleReg[0];
      next_rdata[SW-1:0] = swingReg[SW-1:0];
    end else if (arIdx == bank_cfg_pkg::IDX_OUT1) begin
      next_rdata[bank_cfg_pkg::POS_OUTPD] = outPdReg[1];
      next_rdata[bank_cfg_pkg::POS_STYLE] = styleReg[1];
      next_rdata[SW-1:0] = swingReg[2*SW-1:SW];
    end else begin
      next_rerr = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= bank_cfg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rerr ? bank_cfg_pkg::RESP_SLVERR : bank_cfg_pkg::RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule

//--- verification/axi_cfg_sva.sv
`timescale 1ns/100ps
module axi_cfg_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic hit;
  assign hit = s_axi_araddr[9:2] inside {bank_cfg_pkg::IDX_INIT, bank_cfg_pkg::IDX_DIV,
    bank_cfg_pkg::IDX_BANK, bank_cfg_pkg::IDX_OUT0, bank_cfg_pkg::IDX_OUT1};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence aw_take; s_axi_awvalid && s_axi_awready; endsequence
  sequence w_take; s_axi_wvalid && s_axi_wready; endsequence
  sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
  // ==========================
  // Bus handshakes
  aw_drop_a: assert property (aw_take |=> !s_axi_awready)
    else $error("awready high after take");
  wr_resp_a: assert property (aw_take ##0 w_take |=> ##1 s_axi_bvalid)
    else $error("no write response");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rd_resp_a: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("no read response");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_okay_a: assert property (
    ar_take ##0 hit |=>
      s_axi_rresp == bank_cfg_pkg::RESP_OKAY && s_axi_rdata[31:8] == 24'h0)
    else $error("mapped read wrong");
  rd_miss_a: assert property (
    ar_take ##0 !hit |=>
      s_axi_rresp == bank_cfg_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read wrong");
endmodule
bind output_bank_config_control axi_cfg_sva axi_cfg_sva_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

//--- verification/cfg_host_model.sv
`timescale 1ns/100ps
module cfg_host_model (
  input wire logic clk,
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
  end
  // ==========================
  // Bus cycles
  // reserved bits zero
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    r = bresp;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
endmodule

//--- verification/tb.sv
`timescale 1ns/100ps
module tb;
  logic sys_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, bankPowerDown;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, outSwing;
  logic [1:0] bresp, rresp, ctrlPins, outPowerDown, outStyle, r;
  logic [5:0] divRatio;
  int err_total = 0;
  int total_checks = 0;
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  output_bank_config_control output_bank_config_control_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ctrlPins(ctrlPins), .divRatio(divRatio),
    .bankPowerDown(bankPowerDown), .outPowerDown(outPowerDown), .outStyle(outStyle),
    .outSwing(outSwing));
  cfg_host_model cfg_host_model_i (.clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Ratio, bank off, output off, style, swing
  task automatic outs(input logic [14:0] exp);
    chk({17'h0, divRatio, bankPowerDown, outPowerDown, outStyle, outSwing}, {17'h0, exp});
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v,
                    input logic [1:0] er = bank_cfg_pkg::RESP_OKAY);
    cfg_host_model_i.wr(a, v, r);
    chk({30'h0, r}, {30'h0, er});
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] ev,
                     input logic [1:0] er = bank_cfg_pkg::RESP_OKAY);
    cfg_host_model_i.rd(a, d, r);
    chk(d, ev);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    ctrlPins = 2'h0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    outs({bank_cfg_pkg::DIV_RESET, 9'h000});
    rdc(12'h054, 32'h0d);
    rdc(12'h058, 32'h0);
    rdc(12'h060, 32'h0);
    for (int c = 0; c < 4; c++) begin
      ctrlPins <= c[1:0];
      repeat (6) @(posedge sys_clk);
      outs({bank_cfg_pkg::PIN_DIV[c*6 +: 6], 3'h0, {2{bank_cfg_pkg::PIN_STYLE[c]}},
            {2{bank_cfg_pkg::PIN_SWING[c*2 +: 2]}}});
    end
    wr(12'h060, 8'h86);
    wr(12'h064, 8'h01);
    rdc(12'h060, 32'h86);
    outs({6'h04, 3'h1, 2'h0, 4'ha});
    wr(12'h054, 8'h20);
    wr(12'h058, 8'h81);
    ctrlPins <= 2'h0;
    repeat (6) @(posedge sys_clk);
    outs({6'h0d, 3'h5, 2'h1, 4'h6});
    wr(12'h050, 8'h01);
    outs({6'h20, 3'h5, 2'h1, 4'h6});
    wr(12'h054, 8'h11);
    outs({6'h20, 3'h5, 2'h1, 4'h6});
    wr(12'h050, 8'h00);
    outs({6'h11, 3'h5, 2'h1, 4'h6});
    for (int s = 0; s < 3; s++) begin
      wr(12'h064, {s[1], 4'h0, s[0], s[1:0]});
      chk({28'h0, outPowerDown[1], outStyle[1], outSwing[3:2]}, {28'h0, s[1], s[0], s[1:0]});
    end
    rdc(12'h070, 32'h0, bank_cfg_pkg::RESP_SLVERR);
    wr(12'h070, 8'h01, bank_cfg_pkg::RESP_SLVERR);
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    outs({bank_cfg_pkg::DIV_RESET, 9'h000});
    rdc(12'h064, 32'h0);
    rdc(12'h060, 32'h0);
    wrap_up();
  end
endmodule
